// *** hdl/vea_params.svh ***
`ifndef VEA_PARAMS_SVH
`define VEA_PARAMS_SVH

// Command header fields
`define VEA_TYPE_LSB        29
`define VEA_TYPE_PIPE       3'h3
`define VEA_SUBTYPE_LSB     27
`define VEA_SUBTYPE_3D      2'h3
`define VEA_OPCODE_LSB      24
`define VEA_OPCODE_STATE    3'h0
`define VEA_OPCODE_DRAW     3'h3
`define VEA_SUBOP_LSB       16
`define VEA_SUBOP_ELEMENTS  8'h09
`define VEA_SUBOP_DRAW      8'h00
`define VEA_LENGTH_LSB      0
`define VEA_ACCESS_BIT      15
`define VEA_TOPOLOGY_LSB    10

// Element descriptor dword 0
`define VEA_BUFFER_LSB      27
`define VEA_VALID_BIT       26
`define VEA_FORMAT_LSB      16
`define VEA_SRC_OFFSET_LSB  0

// Element descriptor dword 1
`define VEA_CTRL0_LSB       28
`define VEA_CTRL1_LSB       24
`define VEA_CTRL2_LSB       20
`define VEA_CTRL3_LSB       16
`define VEA_DEST_LSB        0

// Draw payload dword positions, counted from dword 1
`define VEA_DRAW_POS_COUNT  9'h000
`define VEA_DRAW_POS_START  9'h001
`define VEA_DRAW_POS_BASE   9'h004

`define VEA_MAX_ELEMENTS    18
`define VEA_FIFO_DEPTH      16
`define VEA_PAD_MASK        9'h007
`define VEA_ONE_FLOAT       32'h3F800000
`define VEA_ONE_INTEGER     32'h00000001

`endif

// *** hdl/vea_pkg.sv ***
package vea_pkg;

  typedef enum logic [3:0] {
    st_header    = 4'h0,
    st_elem_data = 4'h1,
    st_draw_data = 4'h2,
    st_skip      = 4'h3,
    st_vertex    = 4'h4,
    st_index     = 4'h5,
    st_element   = 4'h6,
    st_fetch     = 4'h7,
    st_store     = 4'h8,
    st_pad       = 4'h9
  } state_type;

  typedef enum logic [2:0] {
    comp_skip              = 3'h0,
    comp_from_source       = 3'h1,
    comp_zero              = 3'h2,
    comp_one_float         = 3'h3,
    comp_one_integer       = 3'h4,
    comp_vertex_identifier = 3'h5
  } comp_ctrl_type;

endpackage

// *** hdl/vea_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module vea_fifo #(
  parameter int WIDTH = 46,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("vea_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty without a counter
  assign o_in_ready  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
  assign o_out_valid = wr_ptr_reg != rd_ptr_reg;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/vertex_element_assembly.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vea_params.svh"

module vertex_element_assembly
  import vea_pkg::*;
#(
  parameter int MAX_ELEMENTS = `VEA_MAX_ELEMENTS,
  parameter int FIFO_DEPTH   = `VEA_FIFO_DEPTH
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_cmd_valid,
  output logic              o_cmd_ready,
  input  wire logic [31:0]  i_cmd_data,
  output logic              o_index_req,
  output logic [31:0]       o_index_position,
  input  wire logic         i_index_valid,
  input  wire logic [31:0]  i_index_data,
  output logic [4:0]        o_fetch_buffer,
  input  wire logic [31:0]  i_buffer_base,
  input  wire logic [10:0]  i_buffer_pitch,
  input  wire logic [31:0]  i_buffer_max_index,
  output logic              o_fetch_req,
  output logic [31:0]       o_fetch_address,
  output logic [8:0]        o_fetch_format,
  input  wire logic         i_fetch_valid,
  input  wire logic [127:0] i_fetch_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [31:0]       o_out_data,
  output logic [7:0]        o_out_offset,
  output logic [4:0]        o_out_topology,
  output logic              o_out_end,
  output logic [4:0]        o_element_count,
  output logic              o_access_random,
  output logic              o_busy
);
  localparam int IW    = $clog2(MAX_ELEMENTS);
  localparam int OUT_W = 46;

  if (MAX_ELEMENTS < 2 || MAX_ELEMENTS > 31) begin : g_bad_elements
    $error("MAX_ELEMENTS must lie between 2 and 31");
  end

  function automatic logic [2:0] ctrl_of(input logic [31:0] dw1, input logic [1:0] c);
    logic [2:0] v;
    case (c)
      2'h0: v = dw1[`VEA_CTRL0_LSB +: 3];
      2'h1: v = dw1[`VEA_CTRL1_LSB +: 3];
      2'h2: v = dw1[`VEA_CTRL2_LSB +: 3];
      default: v = dw1[`VEA_CTRL3_LSB +: 3];
    endcase
    return v;
  endfunction

  function automatic logic [31:0] comp_value(input logic [2:0] ctrl, input logic [1:0] c,
                                             input logic [127:0] src, input logic [31:0] vid);
    logic [31:0] v;
    case (ctrl)
      comp_from_source:       v = src[{c, 5'h00} +: 32];
      comp_one_float:         v = `VEA_ONE_FLOAT;
      comp_one_integer:       v = `VEA_ONE_INTEGER;
      comp_vertex_identifier: v = vid;
      default:                v = 32'h00000000;
    endcase
    return v;
  endfunction

  state_type   state_reg;
  logic [31:0] desc0_reg [MAX_ELEMENTS];
  logic [31:0] desc1_reg [MAX_ELEMENTS];
  logic [4:0]  elem_count_reg;
  logic [8:0]  dw_left_reg;
  logic [8:0]  dw_pos_reg;
  logic        random_reg;
  logic [4:0]  topo_reg;
  logic [31:0] vcount_reg;
  logic [31:0] start_reg;
  logic [31:0] base_reg;
  logic [31:0] vnum_reg;
  logic [31:0] vindex_reg;
  logic [4:0]  elem_reg;
  logic [1:0]  comp_reg;
  logic [127:0] src_reg;
  logic [8:0]  hw_reg;
  logic [8:0]  pad_reg;
  logic        index_req_reg;
  logic [31:0] index_pos_reg;
  logic        fetch_req_reg;
  logic [31:0] fetch_addr_reg;
  logic [8:0]  fetch_fmt_reg;

  logic [7:0]  hdr_subop;
  logic [8:0]  hdr_payload;
  logic        hdr_pipe;
  logic        is_elements;
  logic        is_draw;
  logic        cmd_take;
  logic [4:0]  slot;
  logic [31:0] cur_d0;
  logic [31:0] cur_d1;
  logic [2:0]  cur_ctrl;
  logic        needs_source;
  logic        elem_last_comp;
  logic [8:0]  store_pos;
  logic [42:0] stride;
  logic [31:0] fetch_addr_next;
  logic        push_valid;
  logic        push_ready;
  logic        push_take;
  logic [OUT_W-1:0] push_word;
  logic [OUT_W-1:0] pop_word;

  assign hdr_subop   = i_cmd_data[`VEA_SUBOP_LSB +: 8];
  assign hdr_payload = {1'b0, i_cmd_data[`VEA_LENGTH_LSB +: 8]} + 9'h001;
  assign hdr_pipe    = i_cmd_data[`VEA_TYPE_LSB +: 3] == `VEA_TYPE_PIPE &&
                       i_cmd_data[`VEA_SUBTYPE_LSB +: 2] == `VEA_SUBTYPE_3D;
  assign is_elements = hdr_pipe && i_cmd_data[`VEA_OPCODE_LSB +: 3] == `VEA_OPCODE_STATE &&
                       hdr_subop == `VEA_SUBOP_ELEMENTS;
  assign is_draw     = hdr_pipe && i_cmd_data[`VEA_OPCODE_LSB +: 3] == `VEA_OPCODE_DRAW &&
                       hdr_subop == `VEA_SUBOP_DRAW;

  assign o_cmd_ready = state_reg == st_header || state_reg == st_elem_data ||
                       state_reg == st_draw_data || state_reg == st_skip;
  assign cmd_take    = i_cmd_valid && o_cmd_ready;
  assign slot        = dw_pos_reg[8:6] != 3'h0 ? 5'h1F : dw_pos_reg[5:1];

  // Descriptor currently walked by the vertex loop
  assign cur_d0   = desc0_reg[elem_reg[IW-1:0]];
  assign cur_d1   = desc1_reg[elem_reg[IW-1:0]];
  assign cur_ctrl = ctrl_of(cur_d1, comp_reg);
  assign needs_source = ctrl_of(cur_d1, 2'h0) == comp_from_source ||
                        ctrl_of(cur_d1, 2'h1) == comp_from_source ||
                        ctrl_of(cur_d1, 2'h2) == comp_from_source ||
                        ctrl_of(cur_d1, 2'h3) == comp_from_source;
  assign elem_last_comp = comp_reg == 2'h3 ||
                          ctrl_of(cur_d1, comp_reg + 2'h1) == comp_skip;
  assign store_pos = {1'b0, cur_d1[`VEA_DEST_LSB +: 8]} + {7'h00, comp_reg};

  // Lookup of the selected buffer's state is answered in the same cycle
  assign o_fetch_buffer  = cur_d0[`VEA_BUFFER_LSB +: 5];
  assign stride          = vindex_reg * i_buffer_pitch;
  assign fetch_addr_next = i_buffer_base + stride[31:0] +
                           {21'h000000, cur_d0[`VEA_SRC_OFFSET_LSB +: 11]};

  always_comb begin
    push_valid = 1'b0;
    push_word  = {1'b0, topo_reg, 8'h00, 32'h00000000};
    if (state_reg == st_store) begin
      push_valid = cur_ctrl != comp_skip;
      push_word  = {1'b0, topo_reg, store_pos[7:0],
                    comp_value(cur_ctrl, comp_reg, src_reg, vindex_reg)};
    end else if (state_reg == st_pad) begin
      push_valid = 1'b1;
      if ((pad_reg & `VEA_PAD_MASK) != 9'h000) begin
        push_word = {1'b0, topo_reg, pad_reg[7:0], 32'h00000000};
      end else begin
        push_word = {1'b1, topo_reg, 8'h00, vindex_reg};
      end
    end
  end

  assign push_take = push_valid && push_ready;

  vea_fifo #(
    .WIDTH (OUT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_out_fifo (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (push_valid),
    .o_in_ready  (push_ready),
    .i_in_data   (push_word),
    .o_out_valid (o_out_valid),
    .i_out_ready (i_out_ready),
    .o_out_data  (pop_word)
  );

  assign o_out_end       = pop_word[45];
  assign o_out_topology  = pop_word[44:40];
  assign o_out_offset    = pop_word[39:32];
  assign o_out_data      = pop_word[31:0];
  assign o_element_count = elem_count_reg;
  assign o_access_random = random_reg;
  assign o_busy          = state_reg != st_header;
  assign o_index_req     = index_req_reg;
  assign o_index_position = index_pos_reg;
  assign o_fetch_req     = fetch_req_reg;
  assign o_fetch_address = fetch_addr_reg;
  assign o_fetch_format  = fetch_fmt_reg;

  // Descriptor storage survives draws until a new definition arrives
  always_ff @(posedge i_clk) begin
    if (state_reg == st_elem_data && cmd_take && slot < 5'(MAX_ELEMENTS)) begin
      if (!dw_pos_reg[0]) begin
        desc0_reg[slot[IW-1:0]] <= i_cmd_data;
      end else begin
        desc1_reg[slot[IW-1:0]] <= i_cmd_data;
      end
    end
  end

  // Command header decode and payload capture
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      elem_count_reg <= 5'h00;
      dw_left_reg    <= 9'h000;
      dw_pos_reg     <= 9'h000;
      random_reg     <= 1'b0;
      topo_reg       <= 5'h00;
      vcount_reg     <= 32'h00000000;
      start_reg      <= 32'h00000000;
      base_reg       <= 32'h00000000;
    end else if (cmd_take) begin
      dw_pos_reg  <= dw_pos_reg + 9'h001;
      dw_left_reg <= dw_left_reg - 9'h001;
      if (state_reg == st_header) begin
        dw_pos_reg  <= 9'h000;
        dw_left_reg <= hdr_payload;
        if (is_elements) begin
          elem_count_reg <= 5'h00;
        end
        if (is_draw) begin
          random_reg <= i_cmd_data[`VEA_ACCESS_BIT];
          topo_reg   <= i_cmd_data[`VEA_TOPOLOGY_LSB +: 5];
        end
      end else if (state_reg == st_elem_data) begin
        // Only a completed pair counts, so a lone trailing dword is ignored
        if (dw_pos_reg[0] && slot < 5'(MAX_ELEMENTS)) begin
          elem_count_reg <= slot + 5'h01;
        end
      end else if (state_reg == st_draw_data) begin
        if (dw_pos_reg == `VEA_DRAW_POS_COUNT) begin
          vcount_reg <= i_cmd_data;
        end
        if (dw_pos_reg == `VEA_DRAW_POS_START) begin
          start_reg <= i_cmd_data;
        end
        if (dw_pos_reg == `VEA_DRAW_POS_BASE) begin
          base_reg <= i_cmd_data;
        end
      end
    end
  end

  // Vertex loop bookkeeping
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      vnum_reg   <= 32'h00000000;
      vindex_reg <= 32'h00000000;
      elem_reg   <= 5'h00;
      comp_reg   <= 2'h0;
      src_reg    <= '0;
      hw_reg     <= 9'h000;
      pad_reg    <= 9'h000;
    end else begin
      case (state_reg)
        st_draw_data: begin
          vnum_reg <= 32'h00000000;
        end
        st_vertex: begin
          elem_reg   <= 5'h00;
          hw_reg     <= 9'h000;
          vindex_reg <= start_reg + vnum_reg;
        end
        st_index: begin
          if (i_index_valid) begin
            vindex_reg <= i_index_data + base_reg;
          end
        end
        st_element: begin
          comp_reg <= 2'h0;
          pad_reg  <= hw_reg;
          if (elem_reg != elem_count_reg) begin
            if (!cur_d0[`VEA_VALID_BIT]) begin
              elem_reg <= elem_reg + 5'h01;
            end else if (needs_source && vindex_reg > i_buffer_max_index) begin
              src_reg <= '0;
            end
          end
        end
        st_fetch: begin
          if (i_fetch_valid) begin
            src_reg <= i_fetch_data;
          end
        end
        st_store: begin
          if (cur_ctrl == comp_skip || push_take) begin
            if (push_take && store_pos >= hw_reg) begin
              hw_reg <= store_pos + 9'h001;
            end
            if (cur_ctrl == comp_skip || elem_last_comp) begin
              elem_reg <= elem_reg + 5'h01;
            end else begin
              comp_reg <= comp_reg + 2'h1;
            end
          end
        end
        st_pad: begin
          if (push_take) begin
            pad_reg <= pad_reg + 9'h001;
            if ((pad_reg & `VEA_PAD_MASK) == 9'h000) begin
              vnum_reg <= vnum_reg + 32'h00000001;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Index and fetch requests, held until answered
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      index_req_reg  <= 1'b0;
      index_pos_reg  <= 32'h00000000;
      fetch_req_reg  <= 1'b0;
      fetch_addr_reg <= 32'h00000000;
      fetch_fmt_reg  <= 9'h000;
    end else begin
      if (state_reg == st_vertex && vnum_reg != vcount_reg && random_reg) begin
        index_req_reg <= 1'b1;
        index_pos_reg <= start_reg + vnum_reg;
      end else if (i_index_valid) begin
        index_req_reg <= 1'b0;
      end
      if (state_reg == st_element && elem_reg != elem_count_reg && cur_d0[`VEA_VALID_BIT] &&
          needs_source && vindex_reg <= i_buffer_max_index) begin
        fetch_req_reg  <= 1'b1;
        fetch_addr_reg <= fetch_addr_next;
        fetch_fmt_reg  <= cur_d0[`VEA_FORMAT_LSB +: 9];
      end else if (i_fetch_valid) begin
        fetch_req_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_reg <= st_header;
    end else begin
      case (state_reg)
        st_header: begin
          if (cmd_take) begin
            if (is_elements) begin
              state_reg <= st_elem_data;
            end else if (is_draw) begin
              state_reg <= st_draw_data;
            end else if (hdr_pipe) begin
              state_reg <= st_skip;
            end
          end
        end
        st_elem_data, st_skip: begin
          if (cmd_take && dw_left_reg == 9'h001) begin
            state_reg <= st_header;
          end
        end
        st_draw_data: begin
          if (cmd_take && dw_left_reg == 9'h001) begin
            state_reg <= st_vertex;
          end
        end
        st_vertex: begin
          if (vnum_reg == vcount_reg) begin
            state_reg <= st_header;
          end else if (random_reg) begin
            state_reg <= st_index;
          end else begin
            state_reg <= st_element;
          end
        end
        st_index: begin
          if (i_index_valid) begin
            state_reg <= st_element;
          end
        end
        st_element: begin
          if (elem_reg == elem_count_reg) begin
            state_reg <= st_pad;
          end else if (cur_d0[`VEA_VALID_BIT]) begin
            if (needs_source && vindex_reg <= i_buffer_max_index) begin
              state_reg <= st_fetch;
            end else begin
              state_reg <= st_store;
            end
          end
        end
        st_fetch: begin
          if (i_fetch_valid) begin
            state_reg <= st_store;
          end
        end
        st_store: begin
          if ((cur_ctrl == comp_skip || push_take) &&
              (cur_ctrl == comp_skip || elem_last_comp)) begin
            state_reg <= st_element;
          end
        end
        st_pad: begin
          if (push_take && (pad_reg & `VEA_PAD_MASK) == 9'h000) begin
            state_reg <= st_vertex;
          end
        end
        default: begin
          state_reg <= st_header;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** tb/vea_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module vea_props #(
  parameter int MAX_ELEMENTS = 18
) (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_cmd_valid,
  input wire logic        o_cmd_ready,
  input wire logic [31:0] i_cmd_data,
  input wire logic        o_index_req,
  input wire logic [31:0] o_index_position,
  input wire logic        i_index_valid,
  input wire logic        o_fetch_req,
  input wire logic [31:0] o_fetch_address,
  input wire logic [8:0]  o_fetch_format,
  input wire logic        i_fetch_valid,
  input wire logic        o_out_valid,
  input wire logic        i_out_ready,
  input wire logic [31:0] o_out_data,
  input wire logic        o_out_end,
  input wire logic [4:0]  o_element_count,
  input wire logic        o_access_random,
  input wire logic        o_busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic hdr;
  assign hdr = i_cmd_valid && o_cmd_ready && !o_busy;
  a_elem_header_taken: assert property (hdr && i_cmd_data[31:16] == 16'h7809 |=> o_busy)
    else $error("element header not decoded");
  a_foreign_ignored: assert property (hdr && i_cmd_data[31:29] != 3'h3 |=> !o_busy)
    else $error("foreign dword not ignored");
  a_draw_header_taken: assert property (hdr && i_cmd_data[31:16] == 16'h7B00 |=> o_busy [*2])
    else $error("draw header not decoded");
  a_count_capped: assert property (o_element_count <= MAX_ELEMENTS)
    else $error("element count above limit");
  a_count_retained: assert property (!o_cmd_ready |=> $stable(o_element_count))
    else $error("element count changed during draw");
  a_index_random_only: assert property (o_index_req |-> o_access_random)
    else $error("index read in sequential mode");
  a_index_req_held: assert property (o_index_req && !i_index_valid |=>
    o_index_req && $stable(o_index_position))
    else $error("index request not held");
  a_fetch_req_held: assert property (o_fetch_req && !i_fetch_valid |=>
    o_fetch_req && $stable({o_fetch_address, o_fetch_format}))
    else $error("fetch request not held");
  a_fetch_req_drop: assert property (o_fetch_req && i_fetch_valid |=> !o_fetch_req)
    else $error("fetch request kept after answer");
  a_out_word_held: assert property (o_out_valid && !i_out_ready |=>
    o_out_valid && $stable({o_out_data, o_out_end}))
    else $error("output word changed while stalled");
  c_index_done: cover property (o_index_req && i_index_valid);
  c_fetch_done: cover property (o_fetch_req && i_fetch_valid);
  c_out_stall: cover property (o_out_valid && !i_out_ready [*8]);
endmodule
`default_nettype wire

// *** tb/vea_memory_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module vea_memory_model (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic [3:0]   i_latency,
  input  wire logic [31:0]  i_max_index,
  input  wire logic [4:0]   i_fetch_buffer,
  input  wire logic         i_fetch_req,
  input  wire logic [31:0]  i_fetch_address,
  input  wire logic         i_index_req,
  input  wire logic [31:0]  i_index_position,
  output logic [31:0]       o_buffer_base,
  output logic [10:0]       o_buffer_pitch,
  output logic [31:0]       o_buffer_max_index,
  output logic              o_fetch_valid,
  output logic [127:0]      o_fetch_data,
  output logic              o_index_valid,
  output logic [31:0]       o_index_data
);
  logic [3:0] fetch_wait_reg;
  logic [3:0] index_wait_reg;
  // Each buffer owns a 16 MiB slot, so a wrong buffer select shows up in the fetched data
  assign o_buffer_base      = {3'h0, i_fetch_buffer, 24'h000000};
  assign o_buffer_pitch     = 11'h010;
  assign o_buffer_max_index = i_max_index;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || o_fetch_valid || !i_fetch_req) begin
      o_fetch_valid  <= 1'b0;
      fetch_wait_reg <= 4'h0;
    end else if (fetch_wait_reg == i_latency) begin
      o_fetch_valid <= 1'b1;
    end else begin
      fetch_wait_reg <= fetch_wait_reg + 4'h1;
    end
  end
  // Component k answers address plus k; between answers the lines keep toggling
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_fetch_data <= '0;
    end else if (i_fetch_req && !o_fetch_valid && fetch_wait_reg == i_latency) begin
      o_fetch_data <= {i_fetch_address + 32'h3, i_fetch_address + 32'h2,
                       i_fetch_address + 32'h1, i_fetch_address};
    end else begin
      o_fetch_data <= ~o_fetch_data;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || o_index_valid || !i_index_req) begin
      o_index_valid  <= 1'b0;
      index_wait_reg <= 4'h0;
    end else if (index_wait_reg == i_latency) begin
      o_index_valid <= 1'b1;
    end else begin
      index_wait_reg <= index_wait_reg + 4'h1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_index_data <= '0;
    end else if (i_index_req && !o_index_valid && index_wait_reg == i_latency) begin
      o_index_data <= {i_index_position[30:0], 1'b0};
    end else begin
      o_index_data <= ~o_index_data;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_vertex_element_assembly.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_vertex_element_assembly;
  logic         i_clk = 0, i_reset_n = 0, i_cmd_valid = 0, i_out_ready = 1;
  logic [31:0]  i_cmd_data = 0, max_index = 0;
  logic [3:0]   latency = 0;
  logic         o_cmd_ready, o_index_req, i_index_valid, o_fetch_req, i_fetch_valid;
  logic         o_out_valid, o_out_end, o_access_random, o_busy;
  logic [31:0]  o_index_position, i_index_data, i_buffer_base, i_buffer_max_index;
  logic [31:0]  o_fetch_address, o_out_data;
  logic [4:0]   o_fetch_buffer, o_out_topology, o_element_count, seen_buffer;
  logic [10:0]  i_buffer_pitch;
  logic [8:0]   o_fetch_format, seen_format;
  logic [127:0] i_fetch_data;
  logic [7:0]   o_out_offset;
  logic [45:0]  got_q[$], exp_q[$];
  int           errors = 0, check_count = 0;

  vertex_element_assembly DUT (.i_clk, .i_reset_n, .i_cmd_valid, .o_cmd_ready, .i_cmd_data,
    .o_index_req, .o_index_position, .i_index_valid, .i_index_data, .o_fetch_buffer,
    .i_buffer_base, .i_buffer_pitch, .i_buffer_max_index, .o_fetch_req, .o_fetch_address,
    .o_fetch_format, .i_fetch_valid, .i_fetch_data, .o_out_valid, .i_out_ready, .o_out_data,
    .o_out_offset, .o_out_topology, .o_out_end, .o_element_count, .o_access_random, .o_busy);
  vea_memory_model u_mem (.i_clk, .i_reset_n, .i_latency(latency), .i_max_index(max_index),
    .i_fetch_buffer(o_fetch_buffer), .i_fetch_req(o_fetch_req), .i_fetch_address(o_fetch_address),
    .i_index_req(o_index_req), .i_index_position(o_index_position), .o_buffer_base(i_buffer_base),
    .o_buffer_pitch(i_buffer_pitch), .o_buffer_max_index(i_buffer_max_index),
    .o_fetch_valid(i_fetch_valid), .o_fetch_data(i_fetch_data), .o_index_valid(i_index_valid),
    .o_index_data(i_index_data));

  initial forever #4 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    if (i_reset_n && o_out_valid && i_out_ready)
      got_q.push_back({o_out_end, o_out_end ? 8'h00 : o_out_offset, o_out_data, o_out_topology});
    if (o_fetch_req) begin
      seen_format <= o_fetch_format;
      seen_buffer <= o_fetch_buffer;
    end
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic hang;
    errors++;
    close_out();
  endtask

  task automatic send(input logic [31:0] w);
    int n;
    @(negedge i_clk);
    i_cmd_valid = 1;
    i_cmd_data = w;
    for (n = 0; n < 500 && o_cmd_ready !== 1'b1; n++) @(negedge i_clk);
    if (n == 500) hang();
    @(posedge i_clk);
  endtask

  // Released data lines show the inverse so a late sample cannot match by luck
  task automatic idle_cmd;
    @(negedge i_clk);
    i_cmd_valid = 0;
    i_cmd_data = ~i_cmd_data;
    @(negedge i_clk);
  endtask

  task automatic wait_idle;
    int n;
    for (n = 0; n < 3000 && (o_busy !== 1'b0 || o_out_valid !== 1'b0); n++) @(negedge i_clk);
    if (n == 3000) hang();
  endtask

  task automatic t_reset;
    check("ready", o_cmd_ready, 1);
    check("out valid", o_out_valid, 0);
    check("busy", o_busy, 0);
    check("count", o_element_count, 0);
  endtask

  task automatic t_counts;
    int len[3] = '{1, 3, 35};
    int cnt[3] = '{1, 2, 18};
    foreach (len[i]) begin
      send({16'h7809, 8'h00, 8'(len[i])});
      repeat (len[i] + 1) send(0);
      idle_cmd();
      check("element count", o_element_count, cnt[i]);
    end
  endtask

  // Controls 2,3,4,5 at dword 0; source 1,1 at dword 4; disabled element at dword 6
  task automatic t_define;
    logic [31:0] d[6] = '{32'h2CC00000, 32'h23450000, 32'h2CC007FF, 32'h11000004,
                          32'h28C00000, 32'h33000006};
    send(32'h78090005);
    foreach (d[i]) send(d[i]);
    idle_cmd();
    check("defined count", o_element_count, 3);
  endtask

  task automatic t_ignore;
    send(32'h78080003);
    repeat (4) send(32'h7B000004);
    send(32'h01000000);
    idle_cmd();
    check("skip busy", o_busy, 0);
    check("skip count", o_element_count, 3);
  endtask

  task automatic t_draw(input logic acc, input logic [4:0] topo, input int cnt,
                        input logic [31:0] st, input logic [31:0] base, input logic [31:0] mx,
                        input logic [3:0] lat, input logic stall);
    logic [31:0] vid, src;
    logic [31:0] v[8];
    got_q.delete();
    exp_q.delete();
    latency = lat;
    max_index = mx;
    i_out_ready = !stall;
    for (int n = 0; n < cnt; n++) begin
      vid = acc ? 2 * (st + n) + base : st + n;
      src = vid > mx ? 32'h0 : 32'h050007FF + vid * 16;
      v = '{0, 32'h3F800000, 1, vid, src, src + (vid <= mx), 0, 0};
      for (int k = 0; k < 8; k++) exp_q.push_back({1'b0, 8'(k), v[k], topo});
      exp_q.push_back({1'b1, 8'h00, vid, topo});
    end
    send({16'h7B00, acc, topo, 10'h004});
    send(cnt);
    send(st);
    send(1);
    send(0);
    send(base);
    idle_cmd();
    if (stall) begin
      repeat (80) @(negedge i_clk);
      check("stalled busy", o_busy, 1);
      i_out_ready = 1;
    end
    wait_idle();
    check("word count", got_q.size(), exp_q.size());
    foreach (exp_q[i]) check("out word", i < got_q.size() ? got_q[i] : 46'h0, exp_q[i]);
    check("access type", o_access_random, acc);
    check("format", seen_format, 9'h0C0);
    check("buffer", seen_buffer, 5'h05);
  endtask

  initial begin
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    i_reset_n = 1;
    t_reset();
    t_counts();
    t_define();
    t_ignore();
    t_draw(0, 5'h05, 2, 7, 0, 32'hFFFFFFFF, 0, 0);
    t_draw(1, 5'h16, 3, 2, 30, 36, 2, 0);
    t_draw(0, 5'h01, 2, 0, 0, 32'hFFFFFFFF, 3, 1);
    close_out();
  end
endmodule

bind vertex_element_assembly vea_props #(.MAX_ELEMENTS(MAX_ELEMENTS)) u_props (.i_clk,
  .i_reset_n, .i_cmd_valid, .o_cmd_ready, .i_cmd_data, .o_index_req, .o_index_position,
  .i_index_valid, .o_fetch_req, .o_fetch_address, .o_fetch_format, .i_fetch_valid, .o_out_valid,
  .i_out_ready, .o_out_data, .o_out_end, .o_element_count, .o_access_random, .o_busy);
`default_nettype wire
